// File: bpc_chk.sv
// Assertion checker for the burst and protection control block
module bpc_chk
(
	input wire logic        sys_clk,        // Clock
	input wire logic        rst,            // Reset
	input wire logic        cs_over_limit,  // Peak limit
	input wire logic        high_line,      // High line
	input wire logic        line_ov,        // Line OV
	input wire logic        line_below_bo,  // Brownout
	input wire logic        over_temp,      // Over temp
	input wire logic        vcc_uv,         // Supply UV
	input wire logic        fb_below_entry, // Entry level
	input wire logic        s_axi_bvalid,   // B valid
	input wire logic        s_axi_bready,   // B ready
	input wire logic [1:0]  s_axi_bresp,    // B code
	input wire logic        gate_en_q,      // Gate
	input wire logic        burst_level2_q, // Level 2
	input wire logic        fb_pullup_en_q, // Pull-up
	input wire logic        sel_src_en_q,   // Source
	input wire logic        burst_mode_q,   // Burst
	input wire logic [1:0]  prot_mode_q,    // Response
	input wire logic [3:0]  updown_q        // Counter
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Two sync flops plus the gate register: three sampled edges at most
	AST_CS_CUT: assert property (cs_over_limit [*3] |=> !gate_en_q)
		else $error("gate drive not cut after peak limit");
	AST_SRC_PULLUP: assert property (sel_src_en_q |-> !fb_pullup_en_q)
		else $error("pull-up and selection source both on");
	// Level may only move while the selection source still runs
	AST_LEVEL_HOLD: assert property ($changed(burst_level2_q) |-> sel_src_en_q)
		else $error("level selection changed after latch set");
	AST_COUNT_RANGE: assert property ($stable(high_line) [*4] |->
		updown_q >= (high_line ? 4'h3 : 4'h1) && updown_q <= (high_line ? 4'ha : 4'h8))
		else $error("up/down counter out of range");
	AST_BURST_ENTRY: assert property ($rose(burst_mode_q) |->
		$past(fb_below_entry, 4) && updown_q == (high_line ? 4'ha : 4'h8))
		else $error("burst entered without its conditions");
	AST_BURST_EXIT: assert property ($fell(burst_mode_q) |->
		##[0:1] updown_q == (high_line ? 4'h3 : 4'h1))
		else $error("counter not loaded on burst exit");
	AST_LOV_MODE: assert property (line_ov [*4] |-> ##[0:2] prot_mode_q == 2'h1)
		else $error("line overvoltage response wrong");
	AST_UV_MODE: assert property ((vcc_uv && !line_ov && !over_temp && !line_below_bo) [*4]
		|-> ##[0:2] prot_mode_q == 2'h2)
		else $error("undervoltage response wrong");
	// A pending write answer may not change or vanish
	AST_BUS_B: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");

	cover property ($rose(burst_mode_q));
	cover property ($fell(burst_mode_q));
	cover property (prot_mode_q == 2'h3);
endmodule

// File: bpc_ctrl.v
// Burst mode and protection control logic of a quasi-resonant flyback controller
//
// Notes on behaviour
// - Current-sense over limit cuts gate drive at once, same switching cycle.
// - High line raises counter range and picks the line-scaled peak limit.
// - Two burst levels; level 1 when feedback above selection reference at sampling.
// - Level 1: 0.31 V limit, 0.90 V entry; level 2: 0.35 V, 1.05 V; exit 2.75 V.
// - Reference low holds the level-detection latch cleared.
// - Latch clear and device off: pull-up detached, selection current source on.
// - At supply turn-on, sample feedback level, choose thresholds, set latch.
// - With latch set, later feedback level changes do not alter selection.
// - Selection source off 2 us after turn-on, then pull-up reconnected.
// - Burst entry after 20 ms of low feedback with counter at 8 or 10.
// - Burst-on comparator restarts internal circuit and switching in burst.
// - Burst switching turns on only at valley count 8 or 10.
// - Burst switching turns off at the selected level's burst current limit.
// - Feedback at burst-off threshold stops switching until it rises again.
// - Feedback above burst-exit threshold leaves burst, normal control resumes.
// - Leaving burst loads up/down counter with 1 or 3.
// - Three protection responses: non-switching, plain and odd-skip auto restart.
// - Each fault is watched only in the operating states where it applies.
// - Faults map to their fixed protection response.
// - Line overvoltage protection follows the overvoltage comparator directly.
// - Brownout set below brownout, released only above brown-in threshold.
// - Up/down counter kept in 1..8 or 3..10; out-of-range steps ignored.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`include "bpc_defines.vh"

module bpc_ctrl
#(
	parameter BLANK_CYC = `BPC_BLANK_CYC               // Burst entry blanking in cycles
)
(
	input  wire        sys_clk,        // Control clock, 250 MHz
	input  wire        rst,            // Synchronous reset, active high
	input  wire        reference_ok,   // Internal reference good
	input  wire        vcc_on,         // Supply above turn-on threshold
	input  wire        fb_above_ref,   // Feedback above selection reference
	input  wire        cs_over_limit,  // Sense above line-scaled peak limit
	input  wire        cs_over_burst,  // Sense above burst current limit
	input  wire        fb_below_entry, // Feedback below burst entry threshold
	input  wire        fb_above_bon,   // Feedback above burst-on threshold
	input  wire        fb_below_boff,  // Feedback at burst-off threshold
	input  wire        fb_above_exit,  // Feedback above burst exit threshold
	input  wire        high_line,      // Bus voltage in high-line range
	input  wire        valley_det,     // Valley detected (zero crossing)
	input  wire        cnt_up,         // Up/down counter up step
	input  wire        cnt_down,       // Up/down counter down step
	input  wire        line_ov,        // Line sense above overvoltage threshold
	input  wire        line_below_bo,  // Line sense below brownout threshold
	input  wire        line_above_bi,  // Line sense above brown-in threshold
	input  wire        vcc_ov,         // Supply overvoltage
	input  wire        vcc_uv,         // Supply undervoltage
	input  wire        over_temp,      // Over temperature
	input  wire        over_load,      // Overload after its blanking
	input  wire        out_ov,         // Output overvoltage
	input  wire        s_axi_awvalid,  // AXI write address valid
	output reg         s_axi_awready,  // AXI write address ready
	input  wire [7:0]  s_axi_awaddr,   // AXI write address
	input  wire        s_axi_wvalid,   // AXI write data valid
	output reg         s_axi_wready,   // AXI write data ready
	input  wire [31:0] s_axi_wdata,    // AXI write data
	input  wire [3:0]  s_axi_wstrb,    // AXI write strobes
	output reg         s_axi_bvalid,   // AXI write response valid
	input  wire        s_axi_bready,   // AXI write response ready
	output reg  [1:0]  s_axi_bresp,    // AXI write response
	input  wire        s_axi_arvalid,  // AXI read address valid
	output reg         s_axi_arready,  // AXI read address ready
	input  wire [7:0]  s_axi_araddr,   // AXI read address
	output reg         s_axi_rvalid,   // AXI read data valid
	input  wire        s_axi_rready,   // AXI read data ready
	output reg  [31:0] s_axi_rdata,    // AXI read data
	output reg  [1:0]  s_axi_rresp,    // AXI read response
	output reg         gate_en_q,      // Gate drive enable
	output reg         burst_level2_q, // Level 2 thresholds selected
	output reg         fb_pullup_en_q, // Internal feedback pull-up connected
	output reg         sel_src_en_q,   // Selection current source on
	output reg         burst_mode_q,   // Burst flip-flop
	output reg  [1:0]  prot_mode_q,    // Active protection response
	output reg  [3:0]  updown_q        // Up/down counter (valley target)
);

	localparam NSYNC = 21;

	// ---------------------------------------------------------------
	// Comparator synchronisers
	// ---------------------------------------------------------------
	wire [NSYNC-1:0] raw = {reference_ok, vcc_on, fb_above_ref, cs_over_limit,
		cs_over_burst, fb_below_entry, fb_above_bon, fb_below_boff, fb_above_exit,
		high_line, valley_det, cnt_up, cnt_down, line_ov, line_below_bo,
		line_above_bi, vcc_ov, vcc_uv, over_temp, over_load, out_ov};
	reg  [NSYNC-1:0] sync1_q;
	reg  [NSYNC-1:0] sync2_q;

	// Two stages; first stage feeds only the second
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1)
		begin : g_sync
			always @(posedge sys_clk)
			begin
				if (rst)
				begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end
				else
				begin
					sync1_q[gi] <= raw[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	wire s_ref   = sync2_q[20];
	wire s_von   = sync2_q[19];
	wire s_fbref = sync2_q[18];
	wire s_csl   = sync2_q[17];
	wire s_csb   = sync2_q[16];
	wire s_entry = sync2_q[15];
	wire s_bon   = sync2_q[14];
	wire s_boff  = sync2_q[13];
	wire s_exit  = sync2_q[12];
	wire s_hl    = sync2_q[11];
	wire s_val   = sync2_q[10];
	wire s_up    = sync2_q[9];
	wire s_dn    = sync2_q[8];
	wire s_lov   = sync2_q[7];
	wire s_bo    = sync2_q[6];
	wire s_bi    = sync2_q[5];
	wire s_vov   = sync2_q[4];
	wire s_vuv   = sync2_q[3];
	wire s_ot    = sync2_q[2];
	wire s_ol    = sync2_q[1];
	wire s_oov   = sync2_q[0];

	// ---------------------------------------------------------------
	// Registers and state
	// ---------------------------------------------------------------
	reg        enable_q;
	reg        latch_q;
	reg        von_d1_q;
	reg  [9:0] sel_cnt_q;
	reg        sel_run_q;
	reg [31:0] blank_q;
	reg  [2:0] state_q;
	reg        brownout_q;
	reg  [3:0] valley_q;
	reg        val_d1_q;
	reg        prev_hl_q;

	wire [3:0] cnt_min = s_hl ? `BPC_CNT_MIN_HIGH : `BPC_CNT_MIN_LOW;
	wire [3:0] cnt_max = s_hl ? `BPC_CNT_MAX_HIGH : `BPC_CNT_MAX_LOW;
	wire       von_rise = s_von & ~von_d1_q;
	wire       val_rise = s_val & ~val_d1_q;

	// Brownout has hysteresis: release needs brown-in, not just leaving brownout
	always @(posedge sys_clk)
	begin
		if (rst)
			brownout_q <= 1'b0;
		else if (s_bo)
			brownout_q <= 1'b1;
		else if (s_bi)
			brownout_q <= 1'b0;
	end

	// Fault gating per operating state, then priority by severity
	wire in_norm = (state_q == `BPC_ST_NORMAL);
	wire in_bon  = (state_q == `BPC_ST_BURST_ON);
	wire in_run  = in_norm | in_bon | (state_q == `BPC_ST_BURST_OFF);
	wire f_ns    = in_run & (s_lov | brownout_q | s_ot);
	wire f_ar    = in_run & s_vuv;
	wire f_os    = ((in_norm | in_bon) & (s_vov | s_oov)) | (in_norm & s_ol);
	wire f_any   = s_lov | brownout_q | s_ot | s_vuv | s_vov | s_oov | s_ol; // Ungated, for release
	reg  [1:0] pm_d;

	always @*
	begin
		if (f_ns)
			pm_d = `BPC_PM_NOSWITCH_AR;
		else if (f_ar)
			pm_d = `BPC_PM_AR;
		else if (f_os)
			pm_d = `BPC_PM_ODDSKIP_AR;
		else
			pm_d = `BPC_PM_NONE;
	end

	// ---------------------------------------------------------------
	// Level detection and selection source
	// ---------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			latch_q        <= 1'b0;
			burst_level2_q <= 1'b0;
			von_d1_q       <= 1'b0;
			sel_cnt_q      <= 10'h000;
			sel_run_q      <= 1'b0;
			sel_src_en_q   <= 1'b0;
			fb_pullup_en_q <= 1'b1;
		end
		else
		begin
			von_d1_q <= s_von;
			if (!s_ref)
				latch_q <= 1'b0;
			else if (von_rise && !latch_q)
			begin
				burst_level2_q <= ~s_fbref;
				latch_q        <= 1'b1;
			end
			// The source must outlive the latch set by 2 us
			if (von_rise && !latch_q && s_ref)
			begin
				sel_run_q <= 1'b1;
				sel_cnt_q <= 10'h000;
			end
			else if (sel_run_q)
			begin
				if (sel_cnt_q == `BPC_SEL_OFF_CYC - 1)
					sel_run_q <= 1'b0;
				else
					sel_cnt_q <= sel_cnt_q + 10'h001;
			end
			sel_src_en_q   <= sel_run_q | (!latch_q && state_q == `BPC_ST_OFF);
			fb_pullup_en_q <= ~(sel_run_q | (!latch_q && state_q == `BPC_ST_OFF));
		end
	end

	// ---------------------------------------------------------------
	// Up/down counter
	// ---------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			updown_q  <= `BPC_CNT_MIN_LOW;
			prev_hl_q <= 1'b0;
		end
		else
		begin
			prev_hl_q <= s_hl;
			if (state_q == `BPC_ST_OFF || prev_hl_q != s_hl)
				updown_q <= cnt_min;
			else if (burst_mode_q && (s_exit || pm_d != `BPC_PM_NONE || !enable_q))
				updown_q <= cnt_min;
			else if (s_up && !s_dn && updown_q < cnt_max)
				updown_q <= updown_q + 4'h1;
			else if (s_dn && !s_up && updown_q > cnt_min)
				updown_q <= updown_q - 4'h1;
		end
	end

	// ---------------------------------------------------------------
	// Operating state, burst flip-flop and gate drive
	// ---------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			state_q      <= `BPC_ST_OFF;
			burst_mode_q <= 1'b0;
			blank_q      <= 32'h0000_0000;
			prot_mode_q  <= `BPC_PM_NONE;
			gate_en_q    <= 1'b0;
			valley_q     <= 4'h0;
			val_d1_q     <= 1'b0;
		end
		else
		begin
			val_d1_q <= s_val;
			// Idle burst restarts the count, else it saturates and never matches the target
			if (gate_en_q || state_q == `BPC_ST_BURST_OFF)
				valley_q <= 4'h0;
			else if (val_rise && valley_q != 4'hf)
				valley_q <= valley_q + 4'h1;
			// Blanking counter restarts whenever normal state, low feedback or counter at maximum drops
			if (in_norm && s_entry && updown_q == cnt_max)
				blank_q <= blank_q + 32'h0000_0001;
			else
				blank_q <= 32'h0000_0000;
			case (state_q)
			`BPC_ST_OFF:
			begin
				gate_en_q <= 1'b0;
				prot_mode_q <= `BPC_PM_NONE;
				if (enable_q && latch_q && s_von && s_ref)
					state_q <= `BPC_ST_NORMAL;
			end
			`BPC_ST_NORMAL, `BPC_ST_BURST_ON, `BPC_ST_BURST_OFF:
			begin
				if (pm_d != `BPC_PM_NONE || !enable_q)
				begin
					prot_mode_q  <= pm_d;
					state_q      <= enable_q ? `BPC_ST_PROTECT : `BPC_ST_OFF;
					burst_mode_q <= 1'b0;
					gate_en_q    <= 1'b0;
				end
				else if (burst_mode_q && s_exit)
				begin
					burst_mode_q <= 1'b0;
					state_q      <= `BPC_ST_NORMAL;
					gate_en_q    <= 1'b0;
				end
				else if (in_norm && blank_q >= BLANK_CYC - 1)
				begin
					burst_mode_q <= 1'b1;
					state_q      <= `BPC_ST_BURST_OFF;
					gate_en_q    <= 1'b0;
				end
				else if (state_q == `BPC_ST_BURST_OFF)
				begin
					gate_en_q <= 1'b0;
					if (s_bon)
						state_q <= `BPC_ST_BURST_ON;
				end
				else if (in_bon && s_boff)
				begin
					state_q   <= `BPC_ST_BURST_OFF;
					gate_en_q <= 1'b0;
				end
				else if (gate_en_q)
				begin
					if (s_csl || (in_bon && s_csb))
						gate_en_q <= 1'b0;
				end
				else if (in_bon ? (valley_q == cnt_max)
					: (valley_q >= updown_q))
					gate_en_q <= 1'b1;
			end
			`BPC_ST_PROTECT:
			begin
				// Fault decode is gated off in this state, so release looks at raw faults
				gate_en_q <= 1'b0;
				if (!f_any && s_von)
				begin
					state_q     <= `BPC_ST_NORMAL;
					prot_mode_q <= `BPC_PM_NONE;
				end
			end
			default:
				state_q <= `BPC_ST_OFF;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite slave: one write and one read at a time
	// ---------------------------------------------------------------
	reg        aw_got_q;
	reg        w_got_q;
	reg  [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg  [3:0] w_strb_q;

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			enable_q      <= `BPC_CTRL_ENABLE_RST;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr_q     <= s_axi_awaddr;
				aw_got_q      <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				w_got_q      <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_got_q && w_got_q && !s_axi_bvalid)
			begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr_q == `BPC_ADDR_CTRL)
				begin
					s_axi_bresp <= 2'h0;
					if (w_strb_q[0])
						enable_q <= w_data_q[`BPC_CTRL_ENABLE];
				end
				else
					s_axi_bresp <= 2'h2;        // Unmapped or read-only
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read side answers one cycle after the address is taken
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= 2'h0;
			case (s_axi_araddr)
			`BPC_ADDR_CTRL:   s_axi_rdata <= {31'h0, enable_q};
			`BPC_ADDR_STATUS: s_axi_rdata <= {24'h0, latch_q, burst_level2_q,
				burst_mode_q, gate_en_q, 1'b0, state_q};
			`BPC_ADDR_FAULT:  s_axi_rdata <= {24'h0, brownout_q, s_lov, s_vov,
				s_vuv, s_ot, s_ol, prot_mode_q};
			`BPC_ADDR_COUNT:  s_axi_rdata <= {24'h0, valley_q, updown_q};
			default:
			begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'h2;
			end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// File: bpc_defines.vh
// Constants for the burst and protection control block
`ifndef BPC_DEFINES_VH
`define BPC_DEFINES_VH

// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define BPC_ADDR_CTRL        8'h00
`define BPC_ADDR_STATUS      8'h04
`define BPC_ADDR_FAULT       8'h08
`define BPC_ADDR_COUNT       8'h0c

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define BPC_CTRL_ENABLE      0
`define BPC_CTRL_RESET       32'h0000_0001
`define BPC_CTRL_ENABLE_RST  1'b1

// ---------------------------------------------------------------
// Counter limits
// ---------------------------------------------------------------
`define BPC_CNT_MIN_LOW      4'h1
`define BPC_CNT_MAX_LOW      4'h8
`define BPC_CNT_MIN_HIGH     4'h3
`define BPC_CNT_MAX_HIGH     4'ha

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define BPC_CLK_MHZ          250
`define BPC_SEL_OFF_US       2
`define BPC_SEL_OFF_CYC      (`BPC_SEL_OFF_US * `BPC_CLK_MHZ)
`define BPC_BLANK_MS         20
`define BPC_BLANK_CYC        (`BPC_BLANK_MS * 1000 * `BPC_CLK_MHZ)

// ---------------------------------------------------------------
// Operating states
// ---------------------------------------------------------------
`define BPC_ST_OFF           3'h0
`define BPC_ST_NORMAL        3'h1
`define BPC_ST_BURST_ON      3'h2
`define BPC_ST_BURST_OFF     3'h3
`define BPC_ST_PROTECT       3'h4

// ---------------------------------------------------------------
// Protection responses
// ---------------------------------------------------------------
`define BPC_PM_NONE          2'h0
`define BPC_PM_NOSWITCH_AR   2'h1
`define BPC_PM_AR            2'h2
`define BPC_PM_ODDSKIP_AR    2'h3

`endif

// File: bpc_stage.sv
// Behavioural model of the power stage: sense ramp and valley ringing
module bpc_stage
#(
	parameter int ON_CYC = 6 // On cycles until the sense hits the peak limit
)
(
	input  wire logic sys_clk,       // Clock
	input  wire logic gate_en_q,     // Gate drive
	input  wire logic slow,          // Doubles the ramp time
	output logic      cs_over_limit, // Peak limit reached
	output logic      cs_over_burst, // Burst limit reached
	output logic      valley_det     // Valley seen
);
	logic [4:0] on_q = 5'h00;
	logic [2:0] ring_q = 3'h0;

	// ------------------------------------------------------------
	// Sense ramp and ringing
	// ------------------------------------------------------------
	// Ramp restarts each pulse; the limit stays high until the gate drops
	always @(posedge sys_clk)
	begin
		on_q <= gate_en_q ? on_q + ((on_q == 5'h1f) ? 5'h00 : 5'h01) : 5'h00;
		ring_q <= gate_en_q ? 3'h0 : ring_q + 3'h1;
	end

	// Valley pulses are four cycles wide so they survive the synchroniser
	assign cs_over_limit = gate_en_q && (on_q >= (slow ? 2 * ON_CYC : ON_CYC));
	assign cs_over_burst = gate_en_q && (on_q >= (slow ? 2 * ON_CYC - 2 : ON_CYC - 2));
	assign valley_det = !gate_en_q && ring_q[2];
endmodule

// File: tb.sv
// Top-level testbench for the burst and protection control block
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int ON_CYC = 6;
	localparam logic [1:0] PM [6] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h3, 2'h3};

	logic        sys_clk, rst;
	logic        reference_ok = 0, vcc_on = 0, fb_above_ref = 0, fb_below_entry = 0;
	logic        fb_above_bon = 0, fb_below_boff = 0, fb_above_exit = 0, high_line = 0;
	logic        cnt_up = 0, cnt_down = 0, line_below_bo = 0, line_above_bi = 1, slow = 0;
	logic [5:0]  flt = 6'h00;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, d;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic [1:0]  r;
	wire         line_ov, vcc_uv, out_ov, over_temp, vcc_ov, over_load;
	wire         cs_over_limit, cs_over_burst, valley_det, gate_en_q, burst_mode_q;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp, prot_mode_q;
	wire  [31:0] s_axi_rdata;
	wire         burst_level2_q, fb_pullup_en_q, sel_src_en_q;
	wire  [3:0]  updown_q;
	int          fails = 0, n_tests = 0, cyc = 0, n;

	assign {line_ov, vcc_uv, out_ov, over_temp, vcc_ov, over_load} = flt;

	bpc_ctrl #(.BLANK_CYC(50)) bpc_ctrl_i (.*);
	bpc_stage #(.ON_CYC(ON_CYC)) bpc_stage_i (.*);

	// ------------------------------------------------------------
	// Clock, timeout and helpers
	// ------------------------------------------------------------
	initial
	begin
		sys_clk = 0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Whole run is about a thousand cycles; this only catches a hang
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			test_done();
		end
	end

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tk(input int c);
		repeat (c) @(posedge sys_clk);
	endtask

	// Both channels offered together; each released when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		forever
		begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge sys_clk); // Gap so a following call never reassigns in this step
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		forever
		begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge sys_clk); // Gap so a following call never reassigns in this step
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_bus();
		tk(2);
		chk("sel_src_off_state", 1, sel_src_en_q);
		chk("pullup_off_state", 0, fb_pullup_en_q);
		axr(8'h00, d, r);
		chk("ctrl_reset", 32'h1, d);
		axr(8'h20, d, r);
		chk("unmapped_rresp", 2'h2, r);
		axw(8'h04, 32'hff, r);
		chk("readonly_bresp", 2'h2, r);
		axw(8'h00, 32'h0, r);
		chk("ctrl_write_okay", 2'h0, r);
		axr(8'h00, d, r);
		chk("ctrl_cleared", 32'h0, d);
	endtask

	task automatic t_start();
		fb_above_ref <= 0;
		reference_ok <= 1;
		vcc_on <= 1;
		tk(8);
		chk("level2_sampled", 1, burst_level2_q);
		reference_ok <= 0;
		vcc_on <= 0;
		fb_above_ref <= 1;
		tk(6);
		axr(8'h04, d, r);
		chk("latch_cleared", 0, d[7]);
		reference_ok <= 1;
		vcc_on <= 1;
		tk(8);
		chk("level1_sampled", 0, burst_level2_q);
		chk("sel_src_held", 1, sel_src_en_q);
		for (n = 0; n < 700 && sel_src_en_q; n++) @(posedge sys_clk);
		chk("sel_src_time_ok", 1, n >= 480 && n <= 510);
		chk("pullup_back", 1, fb_pullup_en_q);
		axw(8'h00, 32'h1, r);
		fb_above_ref <= 0;
		tk(6);
		chk("level_kept", 0, burst_level2_q);
	endtask

	task automatic t_gate();
		for (n = 0; n < 300 && !gate_en_q; n++) @(posedge sys_clk);
		chk("gate_on", 1, gate_en_q);
		for (n = 0; n < 40 && gate_en_q; n++) @(posedge sys_clk);
		chk("on_time_ok", 1, n <= ON_CYC + 4);
		high_line <= 1;
		tk(6);
		chk("counter_high_min", 4'h3, updown_q);
		high_line <= 0;
		tk(6);
		repeat (9)
		begin
			cnt_up <= 1;
			tk(1);
			cnt_up <= 0;
			tk(1);
		end
		tk(4);
		chk("counter_top", 4'h8, updown_q);
	endtask

	task automatic t_burst();
		fb_below_entry <= 1;
		tk(30);
		chk("burst_blanked", 0, burst_mode_q);
		for (n = 0; n < 100 && !burst_mode_q; n++) @(posedge sys_clk);
		chk("burst_entered", 1, burst_mode_q);
		flt <= 6'h01;
		tk(8);
		chk("overload_ignored", 2'h0, prot_mode_q);
		flt <= 6'h00;
		fb_above_bon <= 1;
		slow <= 1;
		for (n = 0; n < 300 && !gate_en_q; n++) @(posedge sys_clk);
		chk("burst_restart", 1, gate_en_q);
		fb_above_bon <= 0;
		fb_below_boff <= 1;
		tk(8);
		for (n = 0; n < 40; n++) @(posedge sys_clk) d[0] = n == 0 ? gate_en_q : d[0] | gate_en_q;
		chk("burst_off_idle", 0, d[0]);
		fb_below_boff <= 0;
		fb_below_entry <= 0;
		fb_above_exit <= 1;
		for (n = 0; n < 20 && burst_mode_q; n++) @(posedge sys_clk);
		chk("burst_left", 0, burst_mode_q);
		chk("counter_loaded", 4'h1, updown_q);
		fb_above_exit <= 0;
		fb_above_bon <= 0;
		slow <= 0;
		cnt_down <= 1;
		tk(1);
		cnt_down <= 0;
		tk(4);
		chk("counter_floor", 4'h1, updown_q);
	endtask

	task automatic t_fault();
		for (int i = 0; i < 6; i++)
		begin
			flt <= 6'h20 >> i;
			tk(8);
			chk("fault_response", PM[i], prot_mode_q);
			flt <= 6'h00;
			tk(20);
			chk("fault_released", 2'h0, prot_mode_q);
		end
		line_below_bo <= 1;
		line_above_bi <= 0;
		tk(8);
		chk("brownout_set", 2'h1, prot_mode_q);
		line_below_bo <= 0;
		tk(10);
		chk("brownout_held", 2'h1, prot_mode_q);
		line_above_bi <= 1;
		tk(10);
		chk("brownout_clear", 2'h0, prot_mode_q);
	endtask

	initial
	begin
		rst = 1;
		tk(3);
		chk("reset_pullup", 1, fb_pullup_en_q);
		rst <= 0;
		t_bus();
		t_start();
		t_gate();
		t_burst();
		t_fault();
		test_done();
	end
endmodule

bind bpc_ctrl bpc_chk bpc_chk_i (.*);
